// ### src/usb_bridge_cfg.svh
// Register map, field positions, reset values and widths for the read DMA and power control block
`ifndef USB_BRIDGE_CFG_SVH
`define USB_BRIDGE_CFG_SVH

`define ADDR_W            8
`define DATA_W            32
`define OFS_READ_END      8'h00
`define OFS_READ_EP_PROG  8'h04
`define OFS_READ_BUS_PROG 8'h08
`define OFS_POWER_CTL     8'h0C
`define ADDR_RESET        32'hFFFFFFFF
`define WORD_BYTES        32'h00000004
`define PWR_RESET         8'h32
`define PWR_WAKE_EN       7
`define PWR_REMOTE_WAKE   6
`define PWR_XCVR_RESETB   5
`define PWR_SUSPEND_N     4
`define PWR_XCVR_SLEEP    3
`define PWR_SUPPLY        2
`define PWR_POWER_RESETB  1
`define PWR_BUS_RESET     0

`endif

// ### src/usb_bridge_pkg.sv
// Types shared by the read DMA and power control block
`default_nettype none
`include "usb_bridge_cfg.svh"

package usb_bridge_pkg;

	typedef struct packed {
		logic [`DATA_W-1:0] data;
	} stream_word_s;

	typedef struct packed {
		logic wake_en;
		logic remote_wake;
		logic xcvr_resetb;
		logic suspend_n;
		logic xcvr_sleep;
		logic supply;
		logic power_resetb;
		logic bus_reset;
	} power_ctl_s;

	typedef enum logic [2:0] {
		BUF_EMPTY = 3'b001,
		BUF_ONE   = 3'b010,
		BUF_TWO   = 3'b100
	} buf_state_e;

endpackage : usb_bridge_pkg
`default_nettype wire

// ### src/usb_bridge_read_dma_power_ctl.sv
// Master read DMA progress pointers, two-entry read buffer and power detect control
//
// Notes on behaviour
// - The read end address register is a 32-bit read/write register that resets to all ones.
// - The endpoint progress pointer is read-only, resets to all ones and steps per word moved to the endpoint.
// - The endpoint progress pointer shows completed target-to-endpoint transfer; data may sit in the endpoint FIFO.
// - The system bus progress pointer is read-only, resets to all ones and steps per word taken from the target.
// - The system bus progress pointer shows completed target-to-bridge transfer; data may still be buffered.
// - Power control reads zero in bits 31..8 and holds its eight fields with reset pattern 0,0,1,1,0,0,1,0.
// - With wake enable set, the wake output goes low combinationally as soon as suspend ends.
// - Remote wake is settable only while suspended, drives the core wake input and clears when resume completes.
// - Writing zero to transceiver reset drives the reset output high until software writes one again.
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "usb_bridge_cfg.svh"

module usb_bridge_read_dma_power_ctl
	import usb_bridge_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	// Avalon-MM slave
	input  wire logic [`ADDR_W-1:0]  avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [`DATA_W-1:0]  avs_writedata,
	output logic      [`DATA_W-1:0]  avs_readdata,
	output logic                     avs_waitrequest,
	// Transfer start from the sequencer
	input  wire logic                xfer_start,
	input  wire logic [`DATA_W-1:0]  xfer_start_addr,
	output logic                     xfer_done,
	// Words from the system bus target
	input  wire logic                bus_valid,
	input  wire stream_word_s        bus_word,
	output logic                     bus_ready,
	// Words toward the endpoint
	output logic                     ep_valid,
	output stream_word_s             ep_word,
	input  wire logic                ep_ready,
	// Core and transceiver status
	input  wire logic                suspend_n,
	input  wire logic                xcvr_sleep,
	input  wire logic                supply_present,
	input  wire logic                bus_reset,
	// Power control outputs
	output logic                     wake_n,
	output logic                     core_wake,
	output logic                     transceiver_reset_out,
	output logic                     power_reset_n
);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Every access answers on the second edge; the first edge
	// samples read data so it is stable when waitrequest drops.
	logic               ack_r;
	logic               ack_nxt;
	logic [`DATA_W-1:0] rdata_r;
	logic [`DATA_W-1:0] rdata_nxt;
	logic               wr_go;

	logic [`DATA_W-1:0] end_addr_r;
	logic [`DATA_W-1:0] end_addr_nxt;
	logic [`DATA_W-1:0] ep_ptr_r;
	logic [`DATA_W-1:0] ep_ptr_nxt;
	logic [`DATA_W-1:0] bus_ptr_r;
	logic [`DATA_W-1:0] bus_ptr_nxt;
	power_ctl_s         pwr_r;
	power_ctl_s         pwr_nxt;
	power_ctl_s         pwr_view;

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	// Read data is held between reads, so a late sampler still sees it
	assign avs_readdata    = rdata_r;
	assign wr_go           = avs_write & ack_r;

	// Live status bits are shown as sampled now, not as stored
	always_comb begin
		pwr_view            = pwr_r;
		pwr_view.suspend_n  = suspend_n;
		pwr_view.xcvr_sleep = xcvr_sleep;
		pwr_view.supply     = supply_present;
		pwr_view.bus_reset  = bus_reset;
	end

	// Unmapped offsets read zero and drop writes
	always_comb begin
		ack_nxt   = (avs_read | avs_write) & ~ack_r;
		rdata_nxt = rdata_r;
		if (avs_read && !ack_r) begin
			case (avs_address)
				`OFS_READ_END:      rdata_nxt = end_addr_r;
				`OFS_READ_EP_PROG:  rdata_nxt = ep_ptr_r;
				`OFS_READ_BUS_PROG: rdata_nxt = bus_ptr_r;
				`OFS_POWER_CTL:     rdata_nxt = {24'h000000, pwr_view};
				default:            rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r   <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// End address register
	// ----------------------------------------
	// No check against the start address: an end below it simply
	// holds the target off from the first word.
	logic end_wr;

	assign end_wr = wr_go && (avs_address == `OFS_READ_END);

	always_comb begin
		end_addr_nxt = end_addr_r;
		if (end_wr) begin
			end_addr_nxt = avs_writedata;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			end_addr_r <= `ADDR_RESET;
		end else begin
			end_addr_r <= end_addr_nxt;
		end
	end

	// ----------------------------------------
	// Two-entry read buffer
	// ----------------------------------------
	// Two entries let the target keep streaming for one cycle
	// after the endpoint stalls, so no word is dropped.
	stream_word_s mem_r [2];
	stream_word_s mem_nxt [2];
	logic         wp_r;
	logic         wp_nxt;
	logic         rp_r;
	logic         rp_nxt;
	buf_state_e   buf_r;
	buf_state_e   buf_nxt;
	logic         push;
	logic         pop;
	logic         room;

	// The target is held off once the end address is reached
	assign room      = (bus_ptr_r + `WORD_BYTES) <= end_addr_r;
	assign bus_ready = (buf_r != BUF_TWO) && room;
	// The endpoint always sees the older of two buffered words first
	assign ep_valid  = (buf_r != BUF_EMPTY);
	assign ep_word   = mem_r[rp_r];
	assign push      = bus_valid & bus_ready;
	assign pop       = ep_valid & ep_ready;

	always_comb begin
		mem_nxt = mem_r;
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		buf_nxt = buf_r;
		if (push) begin
			mem_nxt[wp_r] = bus_word;
			wp_nxt        = ~wp_r;
		end
		if (pop) begin
			rp_nxt = ~rp_r;
		end
		case (buf_r)
			BUF_EMPTY: begin
				if (push) begin
					buf_nxt = BUF_ONE;
				end
			end
			BUF_ONE: begin
				if (push && !pop) begin
					buf_nxt = BUF_TWO;
				end else if (pop && !push) begin
					buf_nxt = BUF_EMPTY;
				end
			end
			BUF_TWO: begin
				if (pop) begin
					buf_nxt = BUF_ONE;
				end
			end
			default:   buf_nxt = BUF_EMPTY;
		endcase
		// A start flushes whatever is still buffered; the sequencer
		// must only start once the previous transfer is done.
		if (xfer_start) begin
			wp_nxt  = 1'b0;
			rp_nxt  = 1'b0;
			buf_nxt = BUF_EMPTY;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			wp_r     <= 1'b0;
			rp_r     <= 1'b0;
			buf_r    <= BUF_EMPTY;
		end else begin
			mem_r <= mem_nxt;
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			buf_r <= buf_nxt;
		end
	end

	// ----------------------------------------
	// Progress pointers
	// ----------------------------------------
	// Both pointers name the last byte address already handed on,
	// so a start loads them one word below the start address.
	// Each side steps on its own handshake, so both may move in one cycle.
	always_comb begin
		ep_ptr_nxt  = ep_ptr_r;
		bus_ptr_nxt = bus_ptr_r;
		if (xfer_start) begin
			ep_ptr_nxt  = xfer_start_addr - `WORD_BYTES;
			bus_ptr_nxt = xfer_start_addr - `WORD_BYTES;
		end else begin
			if (pop) begin
				ep_ptr_nxt = ep_ptr_r + `WORD_BYTES;
			end
			if (push) begin
				bus_ptr_nxt = bus_ptr_r + `WORD_BYTES;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ep_ptr_r  <= `ADDR_RESET;
			bus_ptr_r <= `ADDR_RESET;
		end else begin
			ep_ptr_r  <= ep_ptr_nxt;
			bus_ptr_r <= bus_ptr_nxt;
		end
	end

	// Done waits for the buffer to drain as well, so a stalled
	// endpoint holds it low until the last word is taken.
	assign xfer_done = ~room & (buf_r == BUF_EMPTY);

	// ----------------------------------------
	// Power detect control
	// ----------------------------------------
	logic pwr_wr;
	logic xcvr_rst_r;
	logic xcvr_rst_nxt;

	assign pwr_wr = wr_go && (avs_address == `OFS_POWER_CTL);

	always_comb begin
		pwr_nxt = pwr_r;
		// Bits 7, 5 and 1 are plain storage
		if (pwr_wr) begin
			pwr_nxt.wake_en      = avs_writedata[`PWR_WAKE_EN];
			pwr_nxt.xcvr_resetb  = avs_writedata[`PWR_XCVR_RESETB];
			pwr_nxt.power_resetb = avs_writedata[`PWR_POWER_RESETB];
			// A one is only taken while the core reports suspend
			if (avs_writedata[`PWR_REMOTE_WAKE] && !suspend_n) begin
				pwr_nxt.remote_wake = 1'b1;
			end
		end
		// Resume done; set and clear need opposite suspend levels
		if (suspend_n) begin
			pwr_nxt.remote_wake = 1'b0;
		end
		// Live bits are read straight from the pins; their stored copies stay fixed
		pwr_nxt.suspend_n  = 1'b1;
		pwr_nxt.xcvr_sleep = 1'b0;
		pwr_nxt.supply     = 1'b0;
		pwr_nxt.bus_reset  = 1'b0;
		// Reset output gets its own flop so the pin is not behind an inverter
		xcvr_rst_nxt = ~pwr_nxt.xcvr_resetb;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_r      <= `PWR_RESET;
			xcvr_rst_r <= 1'b0;
		end else begin
			pwr_r      <= pwr_nxt;
			xcvr_rst_r <= xcvr_rst_nxt;
		end
	end

	// Wake is a gate, not a flop, so it works with the clock stopped
	assign wake_n                = ~(pwr_r.wake_en & suspend_n);
	assign core_wake             = pwr_r.remote_wake;
	assign transceiver_reset_out = xcvr_rst_r;
	assign power_reset_n         = pwr_r.power_resetb;

endmodule : usb_bridge_read_dma_power_ctl
`default_nettype wire

// ### testbench/usb_bridge_asserts.sv
// Port-level checker for the read DMA and power control block
`timescale 1ns/100ps
`default_nettype none
module usb_bridge_asserts
	import usb_bridge_pkg::*;
(
	input wire logic		ref_clk,
	input wire logic		sys_rst,
	input wire logic [7:0]	avs_address,
	input wire logic		avs_read,
	input wire logic		avs_write,
	input wire logic [31:0]	avs_writedata,
	input wire logic [31:0]	avs_readdata,
	input wire logic		avs_waitrequest,
	input wire logic		bus_valid,
	input wire logic		bus_ready,
	input wire logic		ep_valid,
	input wire stream_word_s	ep_word,
	input wire logic		ep_ready,
	input wire logic		suspend_n,
	input wire logic		wake_n,
	input wire logic		core_wake,
	input wire logic		transceiver_reset_out,
	input wire logic		power_reset_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire pw = avs_write && !avs_waitrequest && avs_address == 8'h0C;
	logic set_ok_r;
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst) set_ok_r <= 1'b0;
		else set_ok_r <= pw && !suspend_n && avs_writedata[6];
	xcvr_reset_a: assert property (pw |=> transceiver_reset_out == !$past(avs_writedata[5]))
		else $error("transceiver reset output wrong");
	pwr_reset_a: assert property (pw |=> power_reset_n == $past(avs_writedata[1]))
		else $error("power reset output wrong");
	wake_en_a: assert property (pw ##1 suspend_n |-> wake_n != $past(avs_writedata[7]))
		else $error("wake output ignores enable");
	wake_low_a: assert property (!wake_n |-> suspend_n)
		else $error("wake low while suspended");
	rwake_clr_a: assert property (core_wake && suspend_n |=> !core_wake)
		else $error("remote wake not cleared");
	rwake_set_a: assert property ($rose(core_wake) |-> set_ok_r)
		else $error("remote wake set wrongly");
	hi_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h0C |-> avs_readdata[31:8] == 24'h0)
		else $error("power control upper bits not zero");
	buf_hold_a: assert property (ep_valid && !ep_ready |=> ep_valid && $stable(ep_word))
		else $error("endpoint word lost in stall");
	word_take_a: assert property (bus_valid && bus_ready |=> ep_valid)
		else $error("taken word not offered");
	rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read answer timing wrong");
endmodule : usb_bridge_asserts
bind usb_bridge_read_dma_power_ctl usb_bridge_asserts chk (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .bus_valid(bus_valid), .bus_ready(bus_ready), .ep_valid(ep_valid),
	.ep_word(ep_word), .ep_ready(ep_ready), .suspend_n(suspend_n), .wake_n(wake_n), .core_wake(core_wake),
	.transceiver_reset_out(transceiver_reset_out), .power_reset_n(power_reset_n)
);
`default_nettype wire

// ### testbench/stream_partner.sv
// Far-side model: system bus target source and endpoint sink
`timescale 1ns/100ps
`default_nettype none
module stream_partner
	import usb_bridge_pkg::*;
(
	input wire logic		ref_clk,
	input wire logic		sys_rst,
	input wire logic		src_en,
	input wire logic		ep_stall,
	output logic			bus_valid,
	output stream_word_s		bus_word,
	input wire logic		bus_ready,
	input wire logic		ep_valid,
	input wire stream_word_s	ep_word,
	output logic			ep_ready,
	output logic [31:0]		n_rx,
	output logic [31:0]		n_bad
);
	logic [31:0] seq_r;
	// Inverse data while idle, so a stale word can never pass as fresh
	assign bus_valid = src_en;
	assign bus_word.data = src_en ? seq_r : ~seq_r;
	assign ep_ready = !ep_stall;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_r <= 32'h0;
			n_rx <= 32'h0;
			n_bad <= 32'h0;
		end else begin
			if (bus_valid && bus_ready)
				seq_r <= seq_r + 32'h1;
			if (ep_valid && ep_ready) begin
				n_rx <= n_rx + 32'h1;
				if (ep_word.data !== n_rx)
					n_bad <= n_bad + 32'h1;
			end
		end
	end
endmodule : stream_partner
`default_nettype wire

// ### testbench/tb.sv
// Testbench for the read DMA and power control block
`timescale 1ns/100ps
`default_nettype none
module tb import usb_bridge_pkg::*;;
	logic ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, xfer_start = 0, ep_stall = 1, src_en = 0;
	logic suspend_n = 1, xcvr_sleep = 0, supply_present = 0, bus_reset = 0;
	logic [7:0] avs_address = 8'h0;
	logic [31:0] avs_writedata = 32'h0, xfer_start_addr = 32'h10, avs_readdata, n_rx, n_bad, q;
	logic avs_waitrequest, xfer_done, bus_valid, bus_ready, ep_valid, ep_ready;
	logic wake_n, core_wake, transceiver_reset_out, power_reset_n;
	stream_word_s bus_word, ep_word;
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	usb_bridge_read_dma_power_ctl uut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .xfer_start(xfer_start), .xfer_start_addr(xfer_start_addr),
		.xfer_done(xfer_done), .bus_valid(bus_valid), .bus_word(bus_word), .bus_ready(bus_ready),
		.ep_valid(ep_valid), .ep_word(ep_word), .ep_ready(ep_ready), .suspend_n(suspend_n),
		.xcvr_sleep(xcvr_sleep), .supply_present(supply_present), .bus_reset(bus_reset), .wake_n(wake_n),
		.core_wake(core_wake), .transceiver_reset_out(transceiver_reset_out), .power_reset_n(power_reset_n)
	);
	stream_partner far_end (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .src_en(src_en), .ep_stall(ep_stall), .bus_valid(bus_valid),
		.bus_word(bus_word), .bus_ready(bus_ready), .ep_valid(ep_valid), .ep_word(ep_word),
		.ep_ready(ep_ready), .n_rx(n_rx), .n_bad(n_bad)
	);
	always #4 ref_clk = ~ref_clk;
	task automatic results();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), e, q);
	endtask : rd
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(8'h00, 32'hFFFFFFFF);
		rd(8'h04, 32'hFFFFFFFF);
		rd(8'h08, 32'hFFFFFFFF);
		rd(8'h0C, 32'h32);
		rd(8'h10, 32'h0);
		acc(1'b1, 8'h04, 32'h0);
		acc(1'b1, 8'h00, 32'h1C);
		rd(8'h04, 32'hFFFFFFFF);
		rd(8'h00, 32'h1C);
		// Endpoint stalled: two words fill the buffer, then the target is held off
		xfer_start <= 1'b1;
		@(posedge ref_clk);
		xfer_start <= 1'b0;
		src_en <= 1'b1;
		do @(posedge ref_clk); while (bus_ready !== 1'b0);
		rd(8'h08, 32'h14);
		rd(8'h04, 32'h0C);
		chk("words at endpoint", 32'h0, n_rx);
		ep_stall <= 1'b0;
		do @(posedge ref_clk); while (xfer_done !== 1'b1);
		src_en <= 1'b0;
		chk("words at endpoint", 32'h4, n_rx);
		chk("bad words", 32'h0, n_bad);
		rd(8'h04, 32'h1C);
		rd(8'h08, 32'h1C);
		xcvr_sleep <= 1'b1;
		supply_present <= 1'b1;
		bus_reset <= 1'b1;
		acc(1'b1, 8'h0C, 32'h0);
		#1 chk("transceiver reset", 32'h1, {31'h0, transceiver_reset_out});
		chk("power reset", 32'h0, {31'h0, power_reset_n});
		rd(8'h0C, 32'h1D);
		acc(1'b1, 8'h0C, 32'h22);
		#1 chk("transceiver reset", 32'h0, {31'h0, transceiver_reset_out});
		acc(1'b1, 8'h0C, 32'h62);
		#1 chk("core wake", 32'h0, {31'h0, core_wake});
		@(posedge ref_clk);
		suspend_n <= 1'b0;
		acc(1'b1, 8'h0C, 32'hE2);
		#1 chk("core wake", 32'h1, {31'h0, core_wake});
		chk("wake", 32'h1, {31'h0, wake_n});
		@(posedge ref_clk);
		suspend_n <= 1'b1;
		#1 chk("wake", 32'h0, {31'h0, wake_n});
		@(posedge ref_clk);
		#1 chk("core wake", 32'h0, {31'h0, core_wake});
		rd(8'h0C, 32'hBF);
		results();
	end
endmodule : tb
`default_nettype wire
